// *** tieg_pkg.sv ***
// Shared constants and types of the timer interrupt enable gating block
package tieg_pkg;
  // Register byte addresses on the APB side
  localparam logic [7:0] OFS_CH_IRQ_EN_BASE = 8'h00;
  localparam logic [7:0] OFS_CH_IRQ_EN_STEP = 8'h04;
  localparam logic [7:0] OFS_CH0_EXTRA = 8'h14;
  localparam logic [7:0] OFS_CH5_PHASE = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // Channel enable register field positions
  localparam int BIT_A = 0;
  localparam int BIT_B = 1;
  localparam int BIT_C = 2;
  // Channel 0 extra enable register field positions
  localparam int BIT_E = 0;
  localparam int BIT_F = 1;
  localparam int BIT_ADC_E = 7;
  // Channel 5 phase enable register field positions
  localparam int BIT_W = 0;
  localparam int BIT_V = 1;
  localparam int BIT_U = 2;

  // Sizes
  localparam int NUM_CH = 5;
  localparam int REQ_W = 18;
  localparam int STAT_W = 19;

  // Writable bits per register; all others read as zero
  localparam logic [7:0] CH_EN_MASK_FULL = 8'h07;
  localparam logic [7:0] CH_EN_MASK_NO_C = 8'h03;
  localparam logic [7:0] CH0_EXTRA_MASK = 8'h83;
  localparam logic [7:0] CH5_PHASE_MASK = 8'h07;

  // Values after reset
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [STAT_W-1:0] STATUS_RESET = 19'h00000;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  // Flag, enable and request carrier; c is ordered ch0, ch3, ch4 from bit 0
  typedef struct packed {
    logic [4:0] a;
    logic [4:0] b;
    logic [2:0] c;
    logic e;
    logic f;
    logic u;
    logic v;
    logic w;
  } tieg_req_type;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tieg_apb_req_type;

  // APB answer from this slave
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tieg_apb_rsp_type;
endpackage

// *** tieg_req_gate.sv ***
// Per-bit AND of status flags and enables into registered request levels
module tieg_req_gate (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [tieg_pkg::REQ_W-1:0] flags,
  input wire logic [tieg_pkg::REQ_W-1:0] enables,
  output logic [tieg_pkg::REQ_W-1:0] reqs
);
  // One flop per request; a level follows both inputs with one cycle of delay
  for (genvar i = 0; i < tieg_pkg::REQ_W; i++) begin : g_bit
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        reqs[i] <= 1'b0;
      end else begin
        reqs[i] <= flags[i] & enables[i];
      end
    end
  end
endmodule

// *** tieg_irq_status.sv ***
// Sticky event status, read-to-clear, mask and one level interrupt
module tieg_irq_status (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [tieg_pkg::STAT_W-1:0] set,
  input wire logic clr,
  input wire logic [tieg_pkg::STAT_W-1:0] clr_bits,
  input wire logic [tieg_pkg::STAT_W-1:0] mask,
  output logic [tieg_pkg::STAT_W-1:0] status,
  output logic irq
);
  logic [tieg_pkg::STAT_W-1:0] next_status;

  // Only bits seen by the read are cleared, and a new event wins over the clear
  always_comb begin
    next_status = status;
    if (clr) begin
      next_status = next_status & ~clr_bits;
    end
    next_status = next_status | set;
  end

  // Status store
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= tieg_pkg::STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // Interrupt tracks the status that is being stored, so it never lags it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & mask);
    end
  end
endmodule

// *** tieg_top.sv ***
// Timer interrupt and converter trigger enable registers with APB access
module tieg_top (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire tieg_pkg::tieg_apb_req_type APB_REQ,
  output tieg_pkg::tieg_apb_rsp_type APB_RSP,
  input wire tieg_pkg::tieg_req_type FLAGS,
  input wire logic MATCH_E_PULSE,
  output tieg_pkg::tieg_req_type REQS,
  output logic ADC_START,
  output logic IRQ_OUT
);
  // Register map, one aligned 32-bit word per register
  //   0x00 channel 0 enables: bit 2 compare C, bit 1 compare B, bit 0 compare A
  //   0x04 channel 1 enables: bit 1 compare B, bit 0 compare A, bit 2 reserved
  //   0x08 channel 2 enables: bit 1 compare B, bit 0 compare A, bit 2 reserved
  //   0x0c channel 3 enables: bit 2 compare C, bit 1 compare B, bit 0 compare A
  //   0x10 channel 4 enables: bit 2 compare C, bit 1 compare B, bit 0 compare A
  //   0x14 channel 0 extra: bit 7 converter start, bit 1 compare F, bit 0 compare E
  //   0x18 channel 5 phase: bit 2 phase U, bit 1 phase V, bit 0 phase W
  //   0x1c event status: sticky, a read clears the bits it returns
  //   0x20 event mask: same layout as the status word
  //   Any other offset answers with an error and changes nothing
  //   Enables and mask read back; status is read only, writes to it are dropped
  //   Upper bits of every word read zero
  //   All enables, status and mask come out of reset as zero

  // Status and mask bit layout; bits 17..0 follow the request vector
  //   bits 17..13 compare A, channels 4 down to 0
  //   bits 12..8 compare B, channels 4 down to 0
  //   bits 7..5 compare C of channels 4, 3 and 0
  //   bit 4 compare E, bit 3 compare F
  //   bits 2..0 phase U, phase V and phase W
  //   bit 18 converter start issued
  //   bits 31..19 always read zero

  // Requests
  //   Each request is its flag ANDed with its enable, one flop deep
  //   Channels 1 and 2 have no compare C request

  // Bus timing, fixed one wait state
  //   Setup cycle, then two access cycles; pready stands in the second
  //   Writes and the status clear land at the edge that ends the transfer
  //   Read data stands only while pready is high and is zero otherwise
  //   Back-to-back transfers are accepted; the next setup may follow at once
  //   An unmapped address gives pslverr with zero read data
  //   pready is never high for more than one cycle

  // Limitations
  //   Channel enable bits 7..3 are not kept here; they read zero
  //   Requests are registered, so they trail flag and enable by one cycle
  //   Status records rising request edges, not the request levels
  //   Only full-word writes; byte strobes and protection bits are not used
  //   Address is 8 bits; everything above 0x20 is unmapped
  //   No separate interrupt line per request; one summary line only

  // Hazards
  //   Event and status read in one cycle: the event is kept for the next read
  //   A request that falls and rises between two reads is recorded once
  //   Ones written to reserved bits are dropped, so they cannot arm anything
  //   The mask acts on the interrupt one cycle after its write lands
  //   Mask changes never touch status; unmasking shows old events one cycle after the write lands
  //   Clearing a flag drops its request a cycle later, enable unchanged
  //   Back-to-back compare E matches give back-to-back converter starts
  //   A read of an unmapped address clears nothing

  // Enable stores
  logic [7:0] ch_irq_en [tieg_pkg::NUM_CH];
  logic [7:0] channel0_extra_enable;
  logic [7:0] channel5_phase_irq_enable;

  // Event status and mask
  logic [tieg_pkg::STAT_W-1:0] irq_mask;
  logic [tieg_pkg::STAT_W-1:0] irq_status;
  logic [tieg_pkg::STAT_W-1:0] status_set;

  // Request path
  logic [tieg_pkg::REQ_W-1:0] req_vec;
  logic [tieg_pkg::REQ_W-1:0] req_prev;
  logic [tieg_pkg::REQ_W-1:0] req_rise;
  tieg_pkg::tieg_req_type enables;

  // Bus answer and decode
  logic [31:0] next_rdata;
  logic next_err;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic setup_seen;
  logic wr_done;
  logic rd_done;
  logic [7:0] wbyte;
  logic [tieg_pkg::NUM_CH-1:0] hit_ch;
  logic hit_extra;
  logic hit_ch5;
  logic hit_status;
  logic hit_mask;
  logic [tieg_pkg::NUM_CH-1:0] wr_ch;
  logic wr_extra;
  logic wr_ch5;
  logic wr_mask;
  logic rd_status;

  // Answer fields come straight from flops
  assign APB_RSP.prdata = prdata;
  assign APB_RSP.pready = pready;
  assign APB_RSP.pslverr = pslverr;
  assign REQS = tieg_pkg::tieg_req_type'(req_vec);

  // Transfer completes at the edge where pready is seen with psel and penable
  assign setup_seen = APB_REQ.psel & APB_REQ.penable & ~pready;
  assign wr_done = APB_REQ.psel & APB_REQ.penable & pready & APB_REQ.pwrite;
  assign rd_done = APB_REQ.psel & APB_REQ.penable & pready & ~APB_REQ.pwrite;
  assign wbyte = APB_REQ.pwdata[7:0];

  // Address decode, one hit per register outside the channel loop
  assign hit_extra = (APB_REQ.paddr == tieg_pkg::OFS_CH0_EXTRA);
  assign hit_ch5 = (APB_REQ.paddr == tieg_pkg::OFS_CH5_PHASE);
  assign hit_status = (APB_REQ.paddr == tieg_pkg::OFS_IRQ_STATUS);
  assign hit_mask = (APB_REQ.paddr == tieg_pkg::OFS_IRQ_MASK);

  // Write and read-clear strobes; nothing moves before the completion edge
  assign wr_extra = wr_done & hit_extra;
  assign wr_ch5 = wr_done & hit_ch5;
  assign wr_mask = wr_done & hit_mask;
  assign rd_status = rd_done & hit_status;

  // One wait state: pready rises at the edge ending the first access cycle, drops after completion
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_seen;
    end
  end

  // Read data and error are prepared together with pready
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata <= tieg_pkg::RDATA_RESET;
      pslverr <= 1'b0;
    end else if (setup_seen) begin
      prdata <= next_rdata;
      pslverr <= next_err;
    end else if (pready) begin
      prdata <= tieg_pkg::RDATA_RESET;
      pslverr <= 1'b0;
    end
  end

  // Channel 0 to 4 enables; bit C exists only where the channel has compare C
  for (genvar ch = 0; ch < tieg_pkg::NUM_CH; ch++) begin : g_ch
    localparam logic [7:0] WMASK = (ch == 1 || ch == 2) ?
      tieg_pkg::CH_EN_MASK_NO_C : tieg_pkg::CH_EN_MASK_FULL;
    localparam logic [7:0] ADDR = 8'(tieg_pkg::OFS_CH_IRQ_EN_BASE +
      8'(ch) * tieg_pkg::OFS_CH_IRQ_EN_STEP);
    // Per-channel decode and write strobe
    assign hit_ch[ch] = (APB_REQ.paddr == ADDR);
    assign wr_ch[ch] = wr_done & hit_ch[ch];
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        ch_irq_en[ch] <= tieg_pkg::ENABLE_RESET;
      end else if (wr_ch[ch]) begin
        ch_irq_en[ch] <= wbyte & WMASK;
      end
    end
  end

  // Channel 0 extra enables; reserved middle bits never store
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      channel0_extra_enable <= tieg_pkg::ENABLE_RESET;
    end else if (wr_extra) begin
      channel0_extra_enable <= wbyte & tieg_pkg::CH0_EXTRA_MASK;
    end
  end

  // Channel 5 phase enables
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      channel5_phase_irq_enable <= tieg_pkg::ENABLE_RESET;
    end else if (wr_ch5) begin
      channel5_phase_irq_enable <= wbyte & tieg_pkg::CH5_PHASE_MASK;
    end
  end

  // Interrupt mask, same layout as the status register
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_mask <= tieg_pkg::STATUS_RESET;
    end else if (wr_mask) begin
      irq_mask <= APB_REQ.pwdata[tieg_pkg::STAT_W-1:0];
    end
  end

  // Read mux and address decode; unmapped addresses answer with an error
  always_comb begin
    next_rdata = tieg_pkg::RDATA_RESET;
    next_err = 1'b1;
    for (int ch = 0; ch < tieg_pkg::NUM_CH; ch++) begin
      if (APB_REQ.paddr == 8'(tieg_pkg::OFS_CH_IRQ_EN_BASE +
          8'(ch) * tieg_pkg::OFS_CH_IRQ_EN_STEP)) begin
        next_rdata = {24'h000000, ch_irq_en[ch]};
        next_err = 1'b0;
      end
    end
    unique case (APB_REQ.paddr)
      tieg_pkg::OFS_CH0_EXTRA: begin
        next_rdata = {24'h000000, channel0_extra_enable};
        next_err = 1'b0;
      end
      tieg_pkg::OFS_CH5_PHASE: begin
        next_rdata = {24'h000000, channel5_phase_irq_enable};
        next_err = 1'b0;
      end
      tieg_pkg::OFS_IRQ_STATUS: begin
        next_rdata = {13'h0000, irq_status};
        next_err = 1'b0;
      end
      tieg_pkg::OFS_IRQ_MASK: begin
        next_rdata = {13'h0000, irq_mask};
        next_err = 1'b0;
      end
      default: begin
        next_rdata = next_rdata;
        next_err = next_err;
      end
    endcase
  end

  // Enable bits gathered into the request layout
  always_comb begin
    enables = '0;
    for (int ch = 0; ch < tieg_pkg::NUM_CH; ch++) begin
      enables.a[ch] = ch_irq_en[ch][tieg_pkg::BIT_A];
      enables.b[ch] = ch_irq_en[ch][tieg_pkg::BIT_B];
    end
    enables.c[0] = ch_irq_en[0][tieg_pkg::BIT_C];
    enables.c[1] = ch_irq_en[3][tieg_pkg::BIT_C];
    enables.c[2] = ch_irq_en[4][tieg_pkg::BIT_C];
    enables.e = channel0_extra_enable[tieg_pkg::BIT_E];
    enables.f = channel0_extra_enable[tieg_pkg::BIT_F];
    enables.u = channel5_phase_irq_enable[tieg_pkg::BIT_U];
    enables.v = channel5_phase_irq_enable[tieg_pkg::BIT_V];
    enables.w = channel5_phase_irq_enable[tieg_pkg::BIT_W];
  end

  // Request levels; a flag cleared by software drops its request the next cycle
  tieg_req_gate u_gate (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .flags(FLAGS),
    .enables(enables),
    .reqs(req_vec)
  );

  // Converter start pulse, one cycle per enabled compare E match
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ADC_START <= 1'b0;
    end else begin
      ADC_START <= MATCH_E_PULSE & channel0_extra_enable[tieg_pkg::BIT_ADC_E];
    end
  end

  // Previous request levels for edge detection of new requests
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      req_prev <= '0;
    end else begin
      req_prev <= req_vec;
    end
  end

  // Rising request edges and converter starts become sticky events
  assign req_rise = req_vec & ~req_prev;
  assign status_set = {ADC_START, req_rise};

  // Read of status clears exactly the bits returned in that read
  tieg_irq_status u_status (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .set(status_set),
    .clr(rd_status),
    .clr_bits(prdata[tieg_pkg::STAT_W-1:0]),
    .mask(irq_mask),
    .status(irq_status),
    .irq(IRQ_OUT)
  );
endmodule

// *** tieg_chk.sv ***
// Port-level checker of the enable gating block
module tieg_chk (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire tieg_pkg::tieg_apb_req_type APB_REQ,
  input wire tieg_pkg::tieg_apb_rsp_type APB_RSP,
  input wire tieg_pkg::tieg_req_type FLAGS,
  input wire logic MATCH_E_PULSE,
  input wire tieg_pkg::tieg_req_type REQS,
  input wire logic ADC_START,
  input wire logic IRQ_OUT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // First access cycle, answer still pending
  sequence s_wait;
    APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready;
  endsequence
  // A request may only follow a flag seen one edge before; u is checked only at the edge where its request rises
  a_c_gated: assert property ((REQS.c & ~$past(FLAGS.c)) == 3'h0)
    else $error("c request without flag");
  a_b_gated: assert property ((REQS.b & ~$past(FLAGS.b)) == 5'h00)
    else $error("b request without flag");
  a_a_gated: assert property ((REQS.a & ~$past(FLAGS.a)) == 5'h00)
    else $error("a request without flag");
  a_f_gated: assert property (REQS.f |-> $past(FLAGS.f))
    else $error("f request without flag");
  a_e_gated: assert property (REQS.e |-> $past(FLAGS.e))
    else $error("e request without flag");
  a_u_gated: assert property ($rose(REQS.u) |-> $past(FLAGS.u))
    else $error("u request without flag");
  a_v_gated: assert property (!$past(FLAGS.v) |-> !REQS.v)
    else $error("v request without flag");
  a_w_gated: assert property (REQS.w |-> $past(FLAGS.w))
    else $error("w request without flag");
  a_adc_cause: assert property (ADC_START |-> $past(MATCH_E_PULSE))
    else $error("converter start without match");
  a_ready_wait: assert property (s_wait |=> APB_RSP.pready ##1 !APB_RSP.pready)
    else $error("bus answer late or held");
endmodule

// *** tieg_far_model.sv ***
// Far-side model: timer status flags and converter start counter
module tieg_far_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [17:0] raise,
  input wire logic [17:0] clear,
  input wire logic adc_start,
  output tieg_pkg::tieg_req_type flags,
  output int adc_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // Flags are sticky; clearing wins, as software clears by writing zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags <= '0;
      adc_count <= 0;
    end else begin
      flags <= tieg_pkg::tieg_req_type'((flags | raise) & ~clear);
      adc_count <= adc_count + int'(adc_start);
    end
  end
endmodule

// *** tieg_top_bench.sv ***
// Self-checking bench of the enable gating block
module tieg_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic match_e = 1'b0;
  logic adc_start, irq_out, err;
  logic [17:0] raise = 18'h00000;
  logic [17:0] clear = 18'h00000;
  logic [31:0] rd;
  logic [7:0] exp_mask [7] = '{8'h07, 8'h03, 8'h03, 8'h07, 8'h07, 8'h83, 8'h07};
  int adc_count, n_errors = 0, tests_run = 0, cycles = 0;
  tieg_pkg::tieg_apb_req_type req = '0;
  tieg_pkg::tieg_apb_rsp_type rsp;
  tieg_pkg::tieg_req_type flags, reqs;

  tieg_top uut (.CORE_CLK(clk), .ARST_N(arst_n), .APB_REQ(req), .APB_RSP(rsp),
    .FLAGS(flags), .MATCH_E_PULSE(match_e), .REQS(reqs), .ADC_START(adc_start),
    .IRQ_OUT(irq_out));
  tieg_far_model far (.clk(clk), .arst_n(arst_n), .raise(raise), .clear(clear),
    .adc_start(adc_start), .flags(flags), .adc_count(adc_count));

  always #20 clk = ~clk;
  // Run should need about 150 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic pulse_e();
    @(posedge clk);
    match_e <= 1'b1;
    @(posedge clk);
    match_e <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    raise <= 18'h3ffff;
    // Every flag up while all enables are still zero
    for (int i = 0; i < 9; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0);
      check(rd, 32'h0);
      raise <= 18'h00000;
    end
    check(32'(reqs), 32'h0);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, 8'(4 * i), 32'hff);
      xfer(1'b0, 8'(4 * i), 32'h0);
      check(rd, {24'h0, exp_mask[i]});
    end
    repeat (2) @(posedge clk);
    check(32'(reqs), 32'h3ffff);
    xfer(1'b1, 8'h04, 32'h0);
    repeat (2) @(posedge clk);
    check(32'(reqs), 32'h3bdff);
    clear <= 18'h00001;
    repeat (3) @(posedge clk);
    check(32'(reqs), 32'h3bdfe);
    $display("test gating done");
    pulse_e();
    check(32'(adc_count), 32'h1);
    xfer(1'b1, 8'h14, 32'h03);
    pulse_e();
    check(32'(adc_count), 32'h1);
    $display("test trigger done");
    // Status is set but masked, so the line stays low until unmasked
    check(32'(irq_out), 32'h0);
    xfer(1'b1, 8'h20, 32'h7ffff);
    repeat (2) @(posedge clk);
    check(32'(irq_out), 32'h1);
    xfer(1'b0, 8'h1c, 32'h0);
    check(rd, 32'h7ffff);
    xfer(1'b0, 8'h1c, 32'h0);
    check(rd, 32'h0);
    @(posedge clk);
    check(32'(irq_out), 32'h0);
    xfer(1'b0, 8'h40, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("test interrupt done");
    final_report();
  end
endmodule

bind tieg_top tieg_chk chk (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .APB_REQ(APB_REQ),
  .APB_RSP(APB_RSP), .FLAGS(FLAGS), .MATCH_E_PULSE(MATCH_E_PULSE), .REQS(REQS),
  .ADC_START(ADC_START), .IRQ_OUT(IRQ_OUT));
